// [logic/i2a_defines.svh]
// Purpose: Shared constants of the two-wire address/data master channel.
// Assumes: Included by file name from the logic/ folder.
// Notes: Counts are in operation clock enables or bit slots.
`ifndef I2A_DEFINES_SVH
`define I2A_DEFINES_SVH

// ****************************************
// Frame layout
// ****************************************
`define I2A_DATA_BITS 4'h8
`define I2A_ACK_SLOT 4'h8
`define I2A_BIT_ZERO 4'h0
`define I2A_BIT_ONE 4'h1

// ****************************************
// Default divider and byte register settings
// ****************************************
`define I2A_DIV_A_RST 8'h00
`define I2A_DIV_B_RST 8'h00
`define I2A_BYTE_RST 8'h00

`endif

// [logic/i2a_pkg.sv]
// Purpose: Types of the two-wire master channel.
// Assumes: Constants live in i2a_defines.svh.
// Notes: Structs group software control and status bits.
package i2a_pkg;

    // ****************************************
    // Frame sequencer states, Gray except on the return from I2A_HIGH to I2A_IDLE
    // ****************************************
    typedef enum logic [1:0] {
        I2A_IDLE = 2'h0,
        I2A_LOW = 2'h1,
        I2A_HIGH = 2'h3
    } i2a_state_e;

    // ****************************************
    // Software control bits
    // ****************************************
    typedef struct packed {
        logic clk_sel;        // 0: prescaler_clock_a, 1: prescaler_clock_b
        logic rx_mode;        // Frame is a reception
        logic output_enable;  // serial_output_enable_bit
        logic data_level;     // data_output_level_bit
        logic clock_level;    // Clock line level while the channel is stopped
    } i2a_cfg_s;

    typedef struct packed {
        logic ack;
        logic overrun;
    } i2a_err_s;

    typedef struct packed {
        logic busy;
        logic channel_on;
        logic buf_full;
        logic overrun;
        logic ack_err;        // ack_error_flag, parity flag position
    } i2a_status_s;

endpackage : i2a_pkg

// [logic/i2a_opclk.sv]
// Purpose: Channel operation clock select and half-bit enable divider.
// Assumes: Single clock domain; all outputs are one-cycle enables.
// Notes: Divider restarts while the frame is not running.
`timescale 1ns/1ps
`include "i2a_defines.svh"

module i2a_opclk #(
    parameter int PSC_W = 8,
    parameter int BIT_W = 7
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Control
    input wire logic i_run,
    input wire logic i_sel,
    input wire logic [PSC_W-1:0] i_div_a,
    input wire logic [PSC_W-1:0] i_div_b,
    input wire logic [BIT_W-1:0] i_bit_div,
    // Enables
    output logic o_half_tick
);

    logic [PSC_W-1:0] cnt_a_r, cnt_a_nxt;
    logic [PSC_W-1:0] cnt_b_r, cnt_b_nxt;
    logic [BIT_W-1:0] cnt_bit_r, cnt_bit_nxt;
    logic tick_r, tick_nxt;
    logic op_en;

    always_comb begin
        cnt_a_nxt = (cnt_a_r >= i_div_a) ? '0 : cnt_a_r + 1'b1;
        cnt_b_nxt = (cnt_b_r >= i_div_b) ? '0 : cnt_b_r + 1'b1;
        // channel_operation_clock source
        op_en = i_sel ? (cnt_b_r >= i_div_b) : (cnt_a_r >= i_div_a);
        cnt_bit_nxt = cnt_bit_r;
        tick_nxt = 1'b0;
        if (!i_run) begin
            cnt_bit_nxt = '0;
        end else if (op_en) begin
            if (cnt_bit_r >= i_bit_div) begin
                cnt_bit_nxt = '0;
                tick_nxt = 1'b1;
            end else begin
                cnt_bit_nxt = cnt_bit_r + 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            cnt_a_r <= '0;
            cnt_b_r <= '0;
            cnt_bit_r <= '0;
            tick_r <= 1'b0;
        end else begin
            cnt_a_r <= cnt_a_nxt;
            cnt_b_r <= cnt_b_nxt;
            cnt_bit_r <= cnt_bit_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign o_half_tick = tick_r;

endmodule : i2a_opclk

// [logic/i2a_master.sv]
// Purpose: Master-only two-wire channel: address, data tx/rx frames.
// Assumes: Software sequences start and stop through the level inputs.
// Notes: One instance per channel; outputs are open-drain enables.
`timescale 1ns/1ps
`include "i2a_defines.svh"

module i2a_master
    import i2a_pkg::*;
#(
    parameter int CH_INDEX = 0,  // 0 or 1
    parameter int PSC_W = 8,
    parameter int BIT_W = 7
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Configuration
    input wire i2a_cfg_s i_cfg,
    input wire logic [PSC_W-1:0] i_div_a,
    input wire logic [PSC_W-1:0] i_div_b,
    input wire logic [BIT_W-1:0] i_bit_div,
    // Software strobes
    input wire logic i_channel_start,
    input wire logic i_channel_stop,
    input wire logic i_data_write,
    input wire logic [7:0] i_tx_byte,
    input wire logic i_rx_read,
    input wire i2a_err_s i_err_clear,
    // Data pin
    input wire logic i_sda_in,
    output logic o_sda_out,
    output logic o_sda_oe,
    // Clock pin
    output logic o_scl_out,
    output logic o_scl_oe,
    // Results
    output logic [7:0] o_rx_byte,
    output i2a_status_s o_status,
    output logic o_transfer_end
);

    // ****************************************
    // Data line synchroniser
    // ****************************************
    logic sda_s1_r, sda_s2_r, sda_s3_r;
    logic sda_lvl_r, sda_lvl_nxt;

    always_comb begin
        sda_lvl_nxt = (sda_s2_r == sda_s3_r) ? sda_s2_r : sda_lvl_r;
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            sda_s1_r <= 1'b1;
            sda_s2_r <= 1'b1;
            sda_s3_r <= 1'b1;
            sda_lvl_r <= 1'b1;
        end else begin
            sda_s1_r <= i_sda_in;
            sda_s2_r <= sda_s1_r;
            sda_s3_r <= sda_s2_r;
            sda_lvl_r <= sda_lvl_nxt;
        end
    end

    // ****************************************
    // Frame sequencer
    // ****************************************
    i2a_state_e state_r, state_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic [7:0] shift_r, shift_nxt;
    logic [7:0] rx_r, rx_nxt;
    logic chan_r, chan_nxt;
    logic rxm_r, rxm_nxt;
    logic full_r, full_nxt;
    logic ovr_r, ovr_nxt;
    logic ack_r, ack_nxt;
    logic end_r, end_nxt;
    logic scl_r, scl_nxt;
    logic sda_r, sda_nxt;
    logic sda_oe_r, sda_oe_nxt, scl_oe_r, scl_oe_nxt;
    logic half_tick;
    logic slot_bit;
    logic ack_set, ovr_set, full_set;

    i2a_opclk #(
        .PSC_W(PSC_W),
        .BIT_W(BIT_W)
    ) i2a_opclk_i (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_run(state_r != I2A_IDLE),
        .i_sel(i_cfg.clk_sel),
        .i_div_a(i_div_a),
        .i_div_b(i_div_b),
        .i_bit_div(i_bit_div),
        .o_half_tick(half_tick)
    );

    always_comb begin
        state_nxt = state_r;
        bit_nxt = bit_r;
        shift_nxt = shift_r;
        rx_nxt = rx_r;
        chan_nxt = chan_r;
        rxm_nxt = rxm_r;
        end_nxt = 1'b0;
        ack_set = 1'b0;
        ovr_set = 1'b0;
        full_set = 1'b0;
        // Start wins over a stop in the same cycle
        if (i_channel_stop) begin
            chan_nxt = 1'b0;
        end
        if (i_channel_start) begin
            chan_nxt = 1'b1;
        end
        // Ack slot: receiver acks unless output enable was cleared
        if (bit_r == `I2A_ACK_SLOT) begin
            slot_bit = !(rxm_r && i_cfg.output_enable);
        end else begin
            slot_bit = shift_r[7];
        end
        case (state_r)
            I2A_IDLE: begin
                // Address or data frame, no parity
                if (chan_r && i_data_write) begin
                    shift_nxt = i_tx_byte;
                    rxm_nxt = i_cfg.rx_mode;
                    bit_nxt = `I2A_BIT_ZERO;
                    state_nxt = I2A_LOW;
                end
            end
            I2A_LOW: begin
                if (half_tick) begin
                    state_nxt = I2A_HIGH;
                end
            end
            I2A_HIGH: begin
                if (half_tick) begin
                    if (bit_r == `I2A_ACK_SLOT) begin
                        state_nxt = I2A_IDLE;
                        end_nxt = 1'b1;
                        if (rxm_r) begin
                            rx_nxt = shift_r;
                            full_set = 1'b1;
                            ovr_set = full_r && !i_rx_read;
                        end else begin
                            ack_set = sda_lvl_r;
                        end
                    end else begin
                        shift_nxt = {shift_r[6:0], sda_lvl_r};
                        bit_nxt = bit_r + `I2A_BIT_ONE;
                        state_nxt = I2A_LOW;
                    end
                end
            end
            default: begin
                state_nxt = I2A_IDLE;
            end
        endcase
        // Flags: a set in the clearing cycle wins
        ack_nxt = (ack_r && !i_err_clear.ack) || ack_set;
        ovr_nxt = (ovr_r && !i_err_clear.overrun) || ovr_set;
        full_nxt = (full_r && !i_rx_read) || full_set;
        // Master owns the clock line; no stretching seen
        case (state_nxt)
            I2A_LOW: scl_nxt = 1'b0;
            I2A_HIGH: scl_nxt = 1'b1;
            default: scl_nxt = chan_nxt ? (scl_r && state_r == I2A_IDLE) : i_cfg.clock_level;
        endcase
        // Software level while output is disabled makes start and stop
        if (!i_cfg.output_enable) begin
            sda_nxt = i_cfg.data_level;
        end else if (state_nxt == I2A_IDLE) begin
            // Hold under a high clock, else setting output enable turns a start into a stop
            sda_nxt = scl_r ? sda_r : 1'b1;
        end else if (state_r == I2A_IDLE) begin
            sda_nxt = i_tx_byte[7];
        end else if (state_r == I2A_HIGH && state_nxt == I2A_LOW) begin
            sda_nxt = (bit_nxt == `I2A_ACK_SLOT) ? !(rxm_r && i_cfg.output_enable)
                                                : shift_nxt[7];
        end else begin
            sda_nxt = slot_bit;
        end
        sda_oe_nxt = !sda_nxt;
        scl_oe_nxt = !scl_nxt;
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state_r <= I2A_IDLE;
            bit_r <= `I2A_BIT_ZERO;
            shift_r <= `I2A_BYTE_RST;
            rx_r <= `I2A_BYTE_RST;
            chan_r <= 1'b0;
            rxm_r <= 1'b0;
            full_r <= 1'b0;
            ovr_r <= 1'b0;
            ack_r <= 1'b0;
            end_r <= 1'b0;
            scl_r <= 1'b1;
            sda_r <= 1'b1;
            sda_oe_r <= 1'b0;
            scl_oe_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            bit_r <= bit_nxt;
            shift_r <= shift_nxt;
            rx_r <= rx_nxt;
            chan_r <= chan_nxt;
            rxm_r <= rxm_nxt;
            full_r <= full_nxt;
            ovr_r <= ovr_nxt;
            ack_r <= ack_nxt;
            end_r <= end_nxt;
            scl_r <= scl_nxt;
            sda_r <= sda_nxt;
            sda_oe_r <= sda_oe_nxt;
            scl_oe_r <= scl_oe_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Open drain: only ever pull low
    assign o_sda_out = 1'b0;
    assign o_scl_out = 1'b0;
    assign o_sda_oe = sda_oe_r;
    assign o_scl_oe = scl_oe_r;
    assign o_rx_byte = rx_r;
    assign o_transfer_end = end_r;
    // Low bit of the Gray state marks a running frame
    assign o_status = '{busy: state_r[0], channel_on: chan_r,
                        buf_full: full_r, overrun: ovr_r, ack_err: ack_r};

    // ****************************************
    // Checks
    // ****************************************
    chk_ack_error: assert property (@(posedge i_clk) disable iff (i_reset)
        (state_r == I2A_HIGH && half_tick && bit_r == `I2A_ACK_SLOT && !rxm_r && sda_lvl_r)
        |=> ack_r)
        else $error("ack error flag not set");
    chk_end_pulse: assert property (@(posedge i_clk) disable iff (i_reset)
        o_transfer_end |=> !o_transfer_end && state_r == I2A_IDLE)
        else $error("transfer end not a single pulse");
    chk_frame_len: assert property (@(posedge i_clk) disable iff (i_reset)
        bit_r <= `I2A_ACK_SLOT)
        else $error("frame longer than nine slots");
    chk_idle_level: assert property (@(posedge i_clk) disable iff (i_reset)
        (!i_cfg.output_enable ##1 !i_cfg.output_enable) |-> o_sda_oe == !$past(i_cfg.data_level))
        else $error("data line does not follow software level");
    chk_msb_first: assert property (@(posedge i_clk) disable iff (i_reset)
        (state_r == I2A_HIGH && bit_r < `I2A_ACK_SLOT && i_cfg.output_enable)
        |-> o_sda_oe == !shift_r[7])
        else $error("data bit not MSB first");
    chk_rx_ack: assert property (@(posedge i_clk) disable iff (i_reset)
        (state_r == I2A_HIGH && bit_r == `I2A_ACK_SLOT && rxm_r && i_cfg.output_enable)
        |-> o_sda_oe)
        else $error("receiver ack not driven");
    chk_overrun: assert property (@(posedge i_clk) disable iff (i_reset)
        (state_r == I2A_HIGH && half_tick && bit_r == `I2A_ACK_SLOT && rxm_r
         && full_r && !i_rx_read) |=> ovr_r && full_r)
        else $error("overrun not flagged");
    chk_clock_phase: assert property (@(posedge i_clk) disable iff (i_reset)
        (state_r == I2A_LOW) |-> ##1 (o_scl_oe || state_r == I2A_HIGH))
        else $error("clock line released in low phase");
    chk_start_gate: assert property (@(posedge i_clk) disable iff (i_reset)
        (state_r == I2A_IDLE && !chan_r) |=> state_r == I2A_IDLE)
        else $error("frame started with channel stopped");

endmodule : i2a_master

// [test/i2a_slave_model.sv]
// Purpose: Behavioural two-wire slave facing the master channel.
// Assumes: Both lines pulled up; the slave never stretches the clock.
// Notes: Slow mode moves its data late in the low phase, as weak slaves do.
`timescale 1ns/1ps
module i2a_slave_model (
    // Bus lines
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_drive,
    // Bench control
    input wire logic i_send,
    input wire logic [7:0] i_send_byte,
    input wire logic i_ack_en,
    input wire logic i_slow,
    // Observed traffic
    output logic [7:0] o_got_byte,
    output logic o_got_ack
);
    int cnt = 0;

    initial begin
        o_sda_drive = 1'b0;
        o_got_byte = 8'h00;
        o_got_ack = 1'b1;
    end

    // Slot 8 is the ack slot; beyond it the line is released
    task automatic upd;
        if (cnt == 8) begin
            o_sda_drive = !i_send && i_ack_en;
        end else if (cnt < 8) begin
            o_sda_drive = i_send && !i_send_byte[7 - cnt];  // MSB first
        end else begin
            o_sda_drive = 1'b0;
        end
    endtask : upd

    // ****************************************
    // Conditions and bit slots
    // ****************************************
    always @(negedge i_sda) if (i_scl) cnt = 0;  // Start seen
    always @(posedge i_sda) if (i_scl) o_sda_drive = 1'b0;  // Stop releases
    always @(i_send or i_send_byte or i_ack_en) if (!i_scl) upd;

    always @(posedge i_scl) begin
        if (cnt < 8) begin
            o_got_byte = {o_got_byte[6:0], i_sda};
        end else begin
            o_got_ack = i_sda;
        end
        cnt = cnt + 1;
    end

    // Data moves only while the clock is low
    always @(negedge i_scl) begin
        if (cnt == 9) cnt = 0;
        #(i_slow ? 60 : 5);
        upd;
    end
endmodule : i2a_slave_model

// [test/i2a_master_test.sv]
// Purpose: Self-checking bench of the two-wire master channel.
// Assumes: Slave model on the far side; lines are wired-and with pull-ups.
// Notes: Half bit is 4 clocks on divider A and 8 on divider B.
`timescale 1ns/1ps
module i2a_master_test;
    import i2a_pkg::*;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    i2a_cfg_s cfg = 5'b00011;
    logic ch_start = 1'b0, ch_stop = 1'b0, wr = 1'b0, rx_read = 1'b0;
    logic [7:0] tx_byte = 8'h00;
    i2a_err_s err_clr = 2'b00;
    logic sda_oe, scl_oe, sda_out, scl_out, t_end, slv_drv, got_ack;
    logic [7:0] rx_byte, got_byte, send_byte = 8'h00;
    logic send = 1'b0, ack_en = 1'b1, slow = 1'b0, p_scl = 1'b1, p_sda = 1'b1;
    i2a_status_s status;
    int error_cnt = 0, samples_checked = 0, rises = 0, bad = 0, cyc;
    logic [6:0] bit_div = 7'h03;
    wire logic scl_w = !scl_oe;
    wire logic sda_w = !(sda_oe || slv_drv);

    i2a_master #(.CH_INDEX(0), .PSC_W(8), .BIT_W(7)) i2a_master_i (
        .i_clk(i_clk), .i_reset(i_reset), .i_cfg(cfg), .i_div_a(8'h00),
        .i_div_b(8'h01), .i_bit_div(bit_div), .i_channel_start(ch_start),
        .i_channel_stop(ch_stop), .i_data_write(wr), .i_tx_byte(tx_byte),
        .i_rx_read(rx_read), .i_err_clear(err_clr), .i_sda_in(sda_w),
        .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_scl_out(scl_out),
        .o_scl_oe(scl_oe), .o_rx_byte(rx_byte), .o_status(status),
        .o_transfer_end(t_end));

    i2a_slave_model i2a_slave_model_i (
        .i_scl(scl_w), .i_sda(sda_w), .o_sda_drive(slv_drv), .i_send(send),
        .i_send_byte(send_byte), .i_ack_en(ack_en), .i_slow(slow),
        .o_got_byte(got_byte), .o_got_ack(got_ack));

    always #12.5 i_clk = !i_clk;
    always @(posedge scl_w) rises++;

    // Data must not move under a high clock inside a frame
    always @(posedge i_clk) begin
        if (status.busy === 1'b1 && scl_w && p_scl && sda_w !== p_sda) bad++;
        p_scl <= scl_w;
        p_sda <= sda_w;
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic tick;
        @(posedge i_clk);
        #2;
    endtask : tick

    task automatic complete_run;
        $display("checked %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic chk_cnt(input int got, input int lo, input int hi, input string what);
        samples_checked++;
        if (got < lo || got > hi) begin
            error_cnt++;
            $display("mismatch at %0t: %s count %0d", $time, what, got);
        end
    endtask : chk_cnt

    // Poke writes again mid-frame, which must be ignored
    task automatic do_frame(input logic [7:0] b, input bit poke);
        tx_byte = b;
        wr = 1'b1;
        rises = 0;
        tick;
        wr = 1'b0;
        cyc = 1;
        while (t_end !== 1'b1 && cyc < 2000) begin
            wr = poke && cyc == 20;
            tx_byte = (poke && cyc == 20) ? ~b : b;
            tick;
            cyc++;
        end
        if (cyc >= 2000) begin
            error_cnt++;
            $display("mismatch at %0t: frame never ended", $time);
            complete_run;
        end
        tick;
        chk(8'(t_end), 8'h00, "end pulse length");
        chk(8'(status.busy), 8'h00, "busy after end");
    endtask : do_frame

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (4) tick;
        i_reset = 1'b0;
        chk({scl_oe, sda_oe, t_end}, 8'h00, "reset outputs");
        chk(8'(status), 8'h00, "reset status");
        chk(8'(sda_w), 8'h01, "idle data level");
        chk({sda_out, scl_out}, 8'h00, "open drain outputs");
        $display("test reset done");
        cfg.data_level = 1'b0;
        tick;
        chk({scl_w, sda_w}, 8'h02, "start condition");
        cfg.output_enable = 1'b1;
        ch_start = 1'b1;
        tick;
        ch_start = 1'b0;
        chk(8'(status.channel_on), 8'h01, "channel on");
        chk({scl_w, sda_w}, 8'h02, "start held");
        do_frame(8'ha5, 1'b1);
        chk(got_byte, 8'ha5, "address frame");
        chk_cnt(rises, 9, 9, "clock pulses");
        chk(8'(status.ack_err), 8'h00, "ack error on ack");
        chk_cnt(cyc, 64, 80, "frame time A");
        $display("test address done");
        ack_en = 1'b0;
        bit_div = 7'h07;
        do_frame(8'h3c, 1'b0);
        bit_div = 7'h03;
        chk(got_byte, 8'h3c, "second frame");
        chk_cnt(cyc, 128, 160, "frame time bit divider");
        chk(8'(status.ack_err), 8'h01, "nack flag");
        err_clr = 2'b10;
        tick;
        err_clr = 2'b00;
        tick;
        chk(8'(status.ack_err), 8'h00, "ack flag clear");
        ack_en = 1'b1;
        cfg.clk_sel = 1'b1;
        do_frame(8'h81, 1'b0);
        chk_cnt(cyc, 128, 160, "frame time B");
        cfg.clk_sel = 1'b0;
        $display("test nack and clock done");
        cfg.rx_mode = 1'b1;
        send = 1'b1;
        slow = 1'b1;
        send_byte = 8'h6b;
        do_frame(8'hff, 1'b0);
        chk(rx_byte, 8'h6b, "received byte");
        chk(8'(got_ack), 8'h00, "master ack");
        chk(8'(status.buf_full), 8'h01, "buffer full");
        send_byte = 8'h94;
        do_frame(8'hff, 1'b0);
        chk(rx_byte, 8'h94, "second byte");
        chk(8'(status.overrun), 8'h01, "overrun flag");
        rx_read = 1'b1;
        err_clr = 2'b01;
        tick;
        rx_read = 1'b0;
        err_clr = 2'b00;
        cfg.output_enable = 1'b0;
        cfg.data_level = 1'b1;
        send_byte = 8'h0f;
        do_frame(8'hff, 1'b0);
        send = 1'b0;
        chk(8'(got_ack), 8'h01, "no ack on last");
        chk(8'(status.overrun), 8'h00, "no overrun");
        $display("test reception done");
        cfg.data_level = 1'b0;
        repeat (4) tick;
        ch_stop = 1'b1;
        tick;
        ch_stop = 1'b0;
        repeat (4) tick;
        cfg.data_level = 1'b1;
        repeat (4) tick;
        chk({scl_w, sda_w}, 8'h03, "lines idle high");
        chk_cnt(bad, 0, 0, "data moved under high clock");
        $display("test stop done");
        complete_run;
    end
endmodule : i2a_master_test
